// ### src/wdt_params.svh
/*
 * constants of the watchdog control block: register addresses, bit
 * positions, reset values and timing counts.
 * assumes: included by the package only; the watchdog module relies on that include.
 */
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// register addresses
`define WDT_CTRL_ADDR       8'h60
`define WDT_CAUSE_ADDR      8'h70

// reset-cause register layout
`define WDT_CAUSE_BIT       3
`define WDT_RDATA_ZERO      8'h00

// reset values
`define WDT_RST_PRESC       4'h0
`define WDT_RST_BIT         1'b0

// fuse level meaning programmed
`define WDT_FUSE_PROGRAMMED 1'b0

// clocks and oscillator divider
`define WDT_MCLK_HZ         20000000
`define WDT_OSC_HZ          128000
`define WDT_OSC_DIV         (`WDT_MCLK_HZ / `WDT_OSC_HZ)
`define WDT_DIV_W           8

// timeout counter
`define WDT_CNT_W           21
`define WDT_BASE_LOG2       11
`define WDT_PRESC_MAX       4'h9

// change-enable window, in mclk cycles
`define WDT_CE_CYCLES       3'h4
`define WDT_CE_LAST         3'h1

`endif

// ### src/wdt_pkg.sv
/*
 * types of the watchdog control block: bus request, core events and
 * the control register layout.
 * assumes: wdt_params.svh is on the include path.
 */
`include "wdt_params.svh"

package wdt_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic gie;
		logic vector_ack;
		logic restart;
	} core_evt_t;

	typedef struct packed {
		logic       flag;
		logic       irq_en;
		logic       presc_hi;
		logic       change_en;
		logic       reset_en;
		logic [2:0] presc_lo;
	} ctrl_t;

endpackage : wdt_pkg

// ### src/watchdog_timer_control.sv
/*
 * watchdog timer control: timeout counter on an oscillator-rate enable,
 * control register, reset-cause flag, interrupt and system reset request.
 * assumes: core, bus master and fuse logic run on mclk; reset_n is the
 * power-on reset and is not asserted by the watchdog's own system reset.
 */
// Chosen here: the strobed register port.
// Operation
// - timeout in interrupt mode sets flag
// - vector execution or write one clears flag
// - irq needs flag, enable and global enable
// - enable bits select stop, irq, reset, both
// - combined: first timeout flags, vector drops enable
// - combined: unserviced flag, next timeout resets
// - programmed fuse forces system reset mode
// - reset-enable clear, prescaler change need window
// - change enable clears four cycles later
// - reset-cause flag holds reset enable high
// - prescaler is bit five plus bits 2..0
// - watchdog stays enabled across its reset
// - counter runs on 128 kHz oscillator rate
// - fuse locks reset enable one, irq zero
// - watchdog reset sets cause, software clears
`timescale 1ns/1ps

module watchdog_timer_control
	import wdt_pkg::*;
#(
	parameter int OSC_DIV           = `WDT_OSC_DIV,
	parameter int TIMEOUT_BASE_LOG2 = `WDT_BASE_LOG2
) (
	// clock and power-on reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	// register port
	input  wire reg_req_t   req,
	output logic      [7:0] rdata_q,
	// core events and fuse
	input  wire core_evt_t  core,
	input  wire logic       always_on_fuse,
	// requests to core and reset controller
	output logic            irq_req_q,
	output logic            sys_reset_q
);

	logic [`WDT_DIV_W-1:0] div_q;
	logic                  tick_q;
	logic [`WDT_CNT_W-1:0] cnt_q;
	logic [`WDT_CNT_W-1:0] limit;
	logic [3:0]            presc_q;
	logic [3:0]            presc_eff;
	logic [2:0]            ce_cnt_q;
	logic                  timeout_irq_flag_q;
	logic                  timeout_irq_enable_q;
	logic                  change_enable_q;
	logic                  wde_q;
	logic                  watchdog_reset_cause_flag_q;
	logic                  fuse_prog;
	logic                  wde_eff;
	logic                  timeout_irq_enable_eff;
	logic                  running;
	logic                  timeout;
	logic                  to_irq;
	logic                  to_reset;
	logic                  ctrl_wr;
	logic                  cause_wr;
	ctrl_t                 wr_c;
	ctrl_t                 rd_c;

	// decode and effective mode
	always_comb begin
		ctrl_wr   = req.wr && (req.addr == `WDT_CTRL_ADDR);
		cause_wr  = req.wr && (req.addr == `WDT_CAUSE_ADDR);
		wr_c      = ctrl_t'(req.wdata);
		fuse_prog = (always_on_fuse == `WDT_FUSE_PROGRAMMED);
		wde_eff   = wde_q | watchdog_reset_cause_flag_q | fuse_prog;
		timeout_irq_enable_eff  = timeout_irq_enable_q & ~fuse_prog;
		running   = wde_eff | timeout_irq_enable_eff;
	end

	always_comb begin
		presc_eff = (presc_q > `WDT_PRESC_MAX) ? `WDT_PRESC_MAX : presc_q;
		limit = `WDT_CNT_W'(1) << (TIMEOUT_BASE_LOG2 + int'(presc_eff));
	end

	// timeout classification
	always_comb begin
		timeout  = running && tick_q && (cnt_q == limit - `WDT_CNT_W'(1));
		to_irq   = timeout && timeout_irq_enable_eff && !(wde_eff && timeout_irq_flag_q);
		to_reset = timeout && wde_eff && (!timeout_irq_enable_eff || timeout_irq_flag_q);
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (div_q == `WDT_DIV_W'(OSC_DIV - 1)) begin
			div_q  <= '0;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + `WDT_DIV_W'(1);
			tick_q <= 1'b0;
		end
	end

	// timeout counter
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
		end else if (core.restart || !running || timeout) begin
			cnt_q <= '0;
		end else if (tick_q) begin
			cnt_q <= cnt_q + `WDT_CNT_W'(1);
		end
	end

	// interrupt flag
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			timeout_irq_flag_q <= `WDT_RST_BIT;
		end else if (to_irq) begin
			timeout_irq_flag_q <= 1'b1;
		end else if (to_reset) begin
			timeout_irq_flag_q <= 1'b0;
		end else if (core.vector_ack || (ctrl_wr && wr_c.flag)) begin
			timeout_irq_flag_q <= 1'b0;
		end
	end

	// interrupt enable
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			timeout_irq_enable_q <= `WDT_RST_BIT;
		end else if (to_reset || fuse_prog) begin
			timeout_irq_enable_q <= 1'b0;
		end else if (ctrl_wr) begin
			timeout_irq_enable_q <= wr_c.irq_en;
		end else if (core.vector_ack && wde_eff && !to_irq) begin
			timeout_irq_enable_q <= 1'b0;
		end
	end

	// change enable window
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			change_enable_q   <= `WDT_RST_BIT;
			ce_cnt_q <= '0;
		end else if (to_reset) begin
			change_enable_q   <= 1'b0;
			ce_cnt_q <= '0;
		end else if (ctrl_wr && wr_c.change_en) begin
			change_enable_q   <= 1'b1;
			ce_cnt_q <= `WDT_CE_CYCLES;
		end else if (ctrl_wr) begin
			change_enable_q   <= 1'b0;
			ce_cnt_q <= '0;
		end else if (change_enable_q) begin
			change_enable_q   <= (ce_cnt_q != `WDT_CE_LAST);
			ce_cnt_q <= ce_cnt_q - 3'h1;
		end
	end

	// system reset enable
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wde_q <= `WDT_RST_BIT;
		end else if (watchdog_reset_cause_flag_q || to_reset) begin
			wde_q <= 1'b1;
		end else if (ctrl_wr) begin
			wde_q <= change_enable_q ? wr_c.reset_en : (wde_q | wr_c.reset_en);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			presc_q <= `WDT_RST_PRESC;
		end else if (to_reset) begin
			presc_q <= `WDT_RST_PRESC;
		end else if (ctrl_wr && change_enable_q) begin
			presc_q <= {wr_c.presc_hi, wr_c.presc_lo};
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_reset_cause_flag_q <= `WDT_RST_BIT;
		end else if (to_reset) begin
			watchdog_reset_cause_flag_q <= 1'b1;
		end else if (cause_wr && !req.wdata[`WDT_CAUSE_BIT]) begin
			watchdog_reset_cause_flag_q <= 1'b0;
		end
	end

	// system reset pulse
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sys_reset_q <= 1'b0;
		end else begin
			sys_reset_q <= to_reset;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_req_q <= 1'b0;
		end else begin
			irq_req_q <= timeout_irq_flag_q && timeout_irq_enable_eff && core.gie;
		end
	end

	// read view of control register
	always_comb begin
		rd_c.flag      = timeout_irq_flag_q;
		rd_c.irq_en    = timeout_irq_enable_eff;
		rd_c.presc_hi  = presc_q[3];
		rd_c.change_en = change_enable_q;
		rd_c.reset_en  = wde_eff;
		rd_c.presc_lo  = presc_q[2:0];
	end

	// read data, one cycle after strobe
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= `WDT_RDATA_ZERO;
		end else if (req.rd && req.addr == `WDT_CTRL_ADDR) begin
			rdata_q <= rd_c;
		end else if (req.rd && req.addr == `WDT_CAUSE_ADDR) begin
			rdata_q <= `WDT_RDATA_ZERO | (8'(watchdog_reset_cause_flag_q) << `WDT_CAUSE_BIT);
		end else begin
			rdata_q <= `WDT_RDATA_ZERO;
		end
	end

	// checks
	sequence s_ce_open;
		ctrl_wr && wr_c.change_en && !to_reset;
	endsequence

	sequence s_quiet4;
		(!ctrl_wr && !to_reset)[*4];
	endsequence

	sequence s_first_timeout;
		to_irq && wde_eff;
	endsequence

	sequence s_vector_combined;
		core.vector_ack && wde_eff && timeout_irq_flag_q && !ctrl_wr && !timeout;
	endsequence

	a_flag_on_timeout: assert property (@(posedge mclk) disable iff (!reset_n)
		timeout && timeout_irq_enable_eff && !wde_eff |=> timeout_irq_flag_q)
		else $error("timeout in interrupt mode did not set flag");

	a_flag_vector_clear: assert property (@(posedge mclk) disable iff (!reset_n)
		(core.vector_ack || (ctrl_wr && wr_c.flag)) && !to_irq |=> !timeout_irq_flag_q)
		else $error("flag not cleared by vector or write one");

	a_irq_gating: assert property (@(posedge mclk) disable iff (!reset_n)
		##1 irq_req_q == $past(timeout_irq_flag_q && timeout_irq_enable_eff && core.gie))
		else $error("irq request does not follow flag and enables");

	a_stopped_idle: assert property (@(posedge mclk) disable iff (!reset_n)
		!running |=> cnt_q == '0 && !sys_reset_q)
		else $error("stopped watchdog counted or reset");

	a_combined_vector: assert property (@(posedge mclk) disable iff (!reset_n)
		s_first_timeout |=> timeout_irq_flag_q && !sys_reset_q)
		else $error("first combined timeout did more than set flag");

	a_vector_drops_ie: assert property (@(posedge mclk) disable iff (!reset_n)
		s_vector_combined |=> !timeout_irq_enable_q && !timeout_irq_flag_q)
		else $error("vector did not drop enable in combined mode");

	a_unserviced_reset: assert property (@(posedge mclk) disable iff (!reset_n)
		timeout && wde_eff && timeout_irq_enable_eff && timeout_irq_flag_q |=> sys_reset_q ##1 !sys_reset_q)
		else $error("unserviced combined timeout gave no one-cycle reset");

	a_fuse_reset: assert property (@(posedge mclk) disable iff (!reset_n)
		fuse_prog && timeout |=> sys_reset_q && !timeout_irq_flag_q)
		else $error("programmed fuse timeout did not reset");

	a_presc_locked: assert property (@(posedge mclk) disable iff (!reset_n)
		ctrl_wr && !change_enable_q && !to_reset |=> $stable(presc_q))
		else $error("prescaler changed outside window");

	a_ce_autoclear: assert property (@(posedge mclk) disable iff (!reset_n)
		s_ce_open ##1 s_quiet4 |=> !change_enable_q)
		else $error("change enable not cleared after four cycles");

	a_cause_holds_wde: assert property (@(posedge mclk) disable iff (!reset_n)
		watchdog_reset_cause_flag_q |=> wde_q && rdata_q[3] == $past(req.rd &&
			(req.addr == `WDT_CTRL_ADDR || req.addr == `WDT_CAUSE_ADDR)))
		else $error("reset enable not held by cause flag");

	a_cause_on_reset: assert property (@(posedge mclk) disable iff (!reset_n)
		sys_reset_q |-> watchdog_reset_cause_flag_q)
		else $error("system reset did not set cause flag");

	a_restart_clears: assert property (@(posedge mclk) disable iff (!reset_n)
		core.restart |=> cnt_q == '0)
		else $error("restart did not clear counter");

	a_fuse_locks_ie: assert property (@(posedge mclk) disable iff (!reset_n)
		fuse_prog |=> !timeout_irq_enable_q && !irq_req_q)
		else $error("programmed fuse left irq enable set");

	a_wde_after_reset: assert property (@(posedge mclk) disable iff (!reset_n)
		sys_reset_q |-> wde_q)
		else $error("reset enable dropped by watchdog reset");

endmodule : watchdog_timer_control

// ### bench/core_model.sv
/*
 * core-side partner: global interrupt enable, restart instruction and
 * vector execution after a chosen delay while a request is shown.
 * assumes: one mclk domain; the bench drives gie, restart and ack settings.
 */
`timescale 1ns/1ps

module core_model
	import wdt_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	// bench controls
	input  wire logic       gie,
	input  wire logic       restart,
	input  wire logic       ack_en,
	input  wire logic [3:0] ack_dly,
	// block side
	input  wire logic       irq_req_q,
	output core_evt_t       core
);
	logic [3:0] wait_q;
	logic       ack_q;

	assign core = '{gie: gie, vector_ack: ack_q, restart: restart};

	// vector runs only once the request has been seen for ack_dly + 1 cycles
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wait_q <= 4'h0;
			ack_q  <= 1'b0;
		end else begin
			ack_q  <= 1'b0;
			wait_q <= 4'h0;
			if (irq_req_q && ack_en && !ack_q) begin
				if (wait_q == ack_dly) begin
					ack_q <= 1'b1;
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
		end
	end
endmodule : core_model

// ### bench/watchdog_timer_control_tb_top.sv
/*
 * self-checking bench of the watchdog control block, with shortened counts.
 * assumes: core_model stands on the core side; fuse changes only in reset.
 */
`timescale 1ns/1ps

module watchdog_timer_control_tb_top;
	import wdt_pkg::*;
	localparam int OD = 2;
	localparam int BL = 2;
	logic       mclk;
	logic       reset_n;
	logic       fuse;
	logic       gie;
	logic       rcmd;
	logic       ack_en;
	logic [3:0] dly;
	logic [3:0] c;
	reg_req_t   req;
	core_evt_t  core;
	logic [7:0] rdata_q;
	logic       irq_req_q;
	logic       sys_reset_q;
	int         n_fail;
	int         n_compared;
	int         n_rst;
	int         seed;
	int         n;
	int         t;

	watchdog_timer_control #(.OSC_DIV(OD), .TIMEOUT_BASE_LOG2(BL)) dut_u (
		.mclk(mclk), .reset_n(reset_n), .req(req), .rdata_q(rdata_q), .core(core),
		.always_on_fuse(fuse), .irq_req_q(irq_req_q), .sys_reset_q(sys_reset_q));

	core_model core_u (
		.mclk(mclk), .reset_n(reset_n), .gie(gie), .restart(rcmd), .ack_en(ack_en),
		.ack_dly(dly), .irq_req_q(irq_req_q), .core(core));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (sys_reset_q === 1'b1) n_rst++;
	end

	initial begin
		#(50 * 40000);
		n_fail++;
		test_done;
	end

	function automatic logic [7:0] pf(input logic [3:0] k);
		pf = {2'b00, k[3], 2'b00, k[2:0]};
	endfunction : pf

	function automatic int ec(input logic [3:0] k);
		ec = OD << (BL + ((k > 4'h9) ? 9 : int'(k)));
	endfunction : ec

	task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		req <= '0;
	endtask : wr

	task rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
		logic [7:0] d;
		@(posedge mclk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		req <= '0;
		#1 d = rdata_q;
		chk(nm, d, e);
	endtask : rdc

	task rst_wd;
		@(posedge mclk);
		rcmd <= 1'b1;
		@(posedge mclk);
		rcmd <= 1'b0;
	endtask : rst_wd

	task idle(input int k);
		repeat (k) @(posedge mclk);
	endtask : idle

	// restart, open the change window, complete it, restart
	task mode(input logic [7:0] v);
		rst_wd;
		wr(8'h60, 8'h18);
		wr(8'h60, v);
		rst_wd;
	endtask : mode

	task run_to(input logic want_rst, output int m);
		m = 0;
		do begin
			@(posedge mclk);
			#1 m++;
		end while (!((want_rst ? sys_reset_q : irq_req_q) === 1'b1) && m < 20000);
		chk("event before limit", {7'b0, m < 20000}, 8'h01);
	endtask : run_to

	task fin(input string nm);
		$display("test %s done", nm);
	endtask : fin

	task test_done;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	initial begin
		seed = 68415;
		n_fail = 0;
		n_compared = 0;
		n_rst = 0;
		reset_n = 1'b0;
		fuse = 1'b1;
		gie = 1'b0;
		rcmd = 1'b0;
		ack_en = 1'b0;
		dly = 4'h2;
		req = '0;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		rdc(8'h60, 8'h00, "ctrl reset");
		rdc(8'h70, 8'h00, "cause reset");
		wr(8'h33, 8'hff);
		rdc(8'h33, 8'h00, "unmapped read");
		rdc(8'h60, 8'h00, "ctrl after unmapped");
		fin("reset");
		mode(8'h07);
		wr(8'h60, 8'h18);
		rdc(8'h60, 8'h1f, "change open");
		idle(6);
		rdc(8'h60, 8'h0f, "change closed");
		wr(8'h60, 8'h03);
		rdc(8'h60, 8'h0f, "locked change");
		fin("window");
		gie <= 1'b1;
		for (t = 0; t < 5; t++) begin
			c = (t == 4) ? 4'hc : 4'(2 + $unsigned($random(seed)) % 4);
			mode(8'h40 | pf(c));
			run_to(1'b0, n);
			chk("period", {7'b0, (n >= ec(c) - 3 * OD) && (n <= ec(c) + 3 * OD + 4)}, 8'h01);
			rdc(8'h60, 8'hc0 | pf(c), "flag set");
			wr(8'h60, 8'hc0 | pf(c));
			rdc(8'h60, 8'h40 | pf(c), "flag write clear");
		end
		fin("irq mode");
		gie <= 1'b0;
		mode(8'h45);
		idle(ec(4'h5) + 3 * OD + 4);
		#1 chk("irq masked", {7'b0, irq_req_q}, 8'h00);
		rdc(8'h60, 8'hc5, "flag while masked");
		ack_en <= 1'b1;
		dly <= 4'(2 + $unsigned($random(seed)) % 8);
		gie <= 1'b1;
		idle(14);
		rdc(8'h60, 8'h45, "vector clears flag");
		fin("mask");
		mode(8'h4d);
		run_to(1'b0, n);
		chk("no reset first", 8'(n_rst), 8'h00);
		idle(14);
		rdc(8'h60, 8'h0d, "vector drops enable");
		wr(8'h60, 8'h4d);
		rst_wd;
		run_to(1'b0, n);
		idle(14);
		rdc(8'h60, 8'h0d, "serviced again");
		chk("still no reset", 8'(n_rst), 8'h00);
		ack_en <= 1'b0;
		wr(8'h60, 8'h4d);
		rst_wd;
		run_to(1'b0, n);
		run_to(1'b1, n);
		chk("unserviced reset", {7'b0, n <= ec(4'h5) + 3 * OD + 4}, 8'h01);
		rdc(8'h70, 8'h08, "cause set");
		rdc(8'h60, 8'h08, "enabled after reset");
		rst_wd;
		wr(8'h60, 8'h18);
		wr(8'h60, 8'h21);
		rdc(8'h60, 8'h29, "cause holds enable");
		wr(8'h70, 8'h00);
		rdc(8'h70, 8'h00, "cause cleared");
		mode(8'h00);
		rdc(8'h60, 8'h00, "watchdog off");
		fin("combined");
		reset_n <= 1'b0;
		fuse <= 1'b0;
		idle(3);
		reset_n <= 1'b1;
		rdc(8'h60, 8'h08, "fuse locks enable");
		wr(8'h60, 8'h40);
		rdc(8'h60, 8'h08, "fuse locks irq");
		rst_wd;
		run_to(1'b1, n);
		chk("fuse reset", {7'b0, n <= ec(4'h0) + 3 * OD + 4}, 8'h01);
		fin("fuse");
		test_done;
	end
endmodule : watchdog_timer_control_tb_top
